// ### verif/gpm_far_side.sv
// far side model: printer, adapter and dma requester levels
`timescale 1ns/10ps
module gpm_far_side (
	input  wire logic [2:0] i_mode,
	input  wire logic       i_dma_role,
	input  wire logic [2:0] i_stim,
	input  wire logic       i_pin39,
	input  wire logic       i_pin39_oe,
	input  wire logic       i_busy_oe,
	input  wire logic       i_ack_oe,
	output logic            o_pin39,
	output logic            o_busy,
	output logic            o_ack
);
	logic drive;
	assign drive = !(i_mode inside {3'h1, 3'h3, 3'h4});
	// open drain with pull-up
	assign o_busy = i_busy_oe ? 1'b0 : drive ? i_stim[0] : 1'b1;
	assign o_ack = i_ack_oe ? 1'b0 : drive ? i_stim[1] : 1'b1;
	assign o_pin39 = i_pin39_oe ? i_pin39 : i_dma_role ? i_stim[2] : !i_pin39;
endmodule

// ### verif/gpm_pin_mux_assertions.sv
// concurrent checks on the pin multiplexer ports
`timescale 1ns/10ps
module gpm_pin_mux_assertions (
	input wire logic       i_ref_clk,
	input wire logic       i_arst_n,
	input wire logic       i_game_mode_select,
	input wire logic       i_floppy_ext_polarity,
	input wire logic       i_ext_mode_polarity,
	input wire logic       i_powerdown_polarity,
	input wire logic       i_powerdown_input,
	input wire logic [7:0] i_powerdown_tristate_reg_a,
	input wire logic [7:0] i_powerdown_tristate_reg_b,
	input wire logic       i_port_mode_bit0,
	input wire logic       i_port_mode_bit1,
	input wire logic       i_port_mode_bit2,
	input wire logic       i_game_read_strobe_n,
	input wire logic       i_game_write_strobe_n,
	input wire logic       i_motor_enable_b_n,
	input wire logic       i_drive_select_b_n,
	input wire logic       i_pin39,
	input wire logic       i_busy_pin,
	input wire logic       i_ack_pin,
	input wire logic       o_pin41,
	input wire logic       o_pin41_oe,
	input wire logic       o_pin39,
	input wire logic       o_pin39_oe,
	input wire logic       o_busy_pin_oe,
	input wire logic       o_ack_pin_oe,
	input wire logic       o_game_port_select,
	input wire logic       o_dma_req_chan_a,
	input wire logic       o_adapter_irq_in,
	input wire logic       o_adapter_dma_req_in,
	input wire logic       o_clock_stop
);
	// ==========================================
	// helpers
	logic [1:0] up;
	logic [2:0] md;
	logic       pd, fl, ex;
	assign md = {i_port_mode_bit2, i_port_mode_bit1, i_port_mode_bit0};
	assign pd = i_powerdown_input == i_powerdown_polarity;
	assign fl = md == 3'h1 || md == 3'h3;
	assign ex = md == 3'h2 || md > 3'h4;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	// ==========================================
	// properties
	property p_clock_stop; up == 2'h3 |-> o_clock_stop == $past(pd); endproperty
	a_clock_stop: assert property (p_clock_stop) else $error("clock stop wrong");
	property p_pin41_oe; up == 2'h3 |-> o_pin41_oe == !$past(pd && i_powerdown_tristate_reg_a[0]); endproperty
	a_pin41_oe: assert property (p_pin41_oe) else $error("pin41 enable wrong");
	property p_motor;
		up == 2'h3 && $past(fl && !(pd && i_powerdown_tristate_reg_b[0])) |-> o_busy_pin_oe == !$past(i_motor_enable_b_n);
	endproperty
	a_motor: assert property (p_motor) else $error("motor drive wrong");
	property p_dsel;
		up == 2'h3 && $past(fl && !(pd && i_powerdown_tristate_reg_b[1])) |-> o_ack_pin_oe == !$past(i_drive_select_b_n);
	endproperty
	a_dsel: assert property (p_dsel) else $error("drive select wrong");
	property p_released; up == 2'h3 && $past(!fl) |-> !o_busy_pin_oe && !o_ack_pin_oe; endproperty
	a_released: assert property (p_released) else $error("status pin driven");
	property p_adapter_in;
		up == 2'h3 && $past(md == 3'h2) |-> o_adapter_irq_in == $past(i_busy_pin) && o_adapter_dma_req_in == $past(i_ack_pin);
	endproperty
	a_adapter_in: assert property (p_adapter_in) else $error("adapter inputs wrong");
	property p_dma; up == 2'h3 && !o_game_port_select |-> !o_pin39_oe && o_dma_req_chan_a == $past(i_pin39); endproperty
	a_dma: assert property (p_dma) else $error("dma pins wrong");
	property p_adapter;
		up == 2'h3 && o_game_port_select && !$past(i_game_mode_select, 2) && !$past(pd)
		|-> o_pin41 == $past(i_game_read_strobe_n) && o_pin39 == $past(i_game_write_strobe_n);
	endproperty
	a_adapter: assert property (p_adapter) else $error("strobes wrong");
	property p_portable;
		up == 2'h3 && o_game_port_select && $past(i_game_mode_select, 2) && !$past(pd)
		|-> o_pin41 == ($past(fl) ~^ $past(i_floppy_ext_polarity)) && o_pin39 == ($past(ex) ~^ $past(i_ext_mode_polarity));
	endproperty
	a_portable: assert property (p_portable) else $error("indicators wrong");
	c_dma: cover property (up == 2'h3 && !o_game_port_select && o_dma_req_chan_a);
	c_portable: cover property (up == 2'h3 && o_game_port_select && $past(i_game_mode_select, 2));
	c_stop: cover property (o_clock_stop);
endmodule
bind gpm_pin_mux gpm_pin_mux_assertions i_chk (.*);

// ### verif/testbench.sv
// random stimulus bench for the pin multiplexer
`timescale 1ns/10ps
module testbench;
	import gpm_pkg::*;
	typedef struct packed {logic p41, p41e, p39, p39e, boe, aoe, gs, dq, pb, pa, ir, ad, cs;} gpm_exp_t;
	logic       i_ref_clk, i_arst_n, i_game_select_strap, i_game_mode_select, i_floppy_ext_polarity;
	logic       i_ext_mode_polarity, i_powerdown_polarity, i_port_mode_bit0, i_port_mode_bit1, i_port_mode_bit2;
	logic       i_powerdown_input, i_game_read_strobe_n, i_game_write_strobe_n, i_dma_ack_chan_a_n;
	logic       i_motor_enable_b_n, i_drive_select_b_n, i_pin41, i_pin39, i_busy_pin, i_ack_pin;
	logic [7:0] i_powerdown_tristate_reg_a, i_powerdown_tristate_reg_b, lfsr;
	logic       o_pin41, o_pin41_oe, o_pin39, o_pin39_oe, o_busy_pin, o_busy_pin_oe, o_ack_pin, o_ack_pin_oe;
	logic       o_game_port_select, o_dma_req_chan_a, o_printer_busy, o_printer_ack_n;
	logic       o_adapter_irq_in, o_adapter_dma_req_in, o_clock_stop;
	logic [2:0] md, stim;
	int         failures, num_checks;
	gpm_exp_t   q[$];
	gpm_exp_t   e;
	gpm_exp_t   last;
	int         avail;
	assign {i_port_mode_bit2, i_port_mode_bit1, i_port_mode_bit0} = md;
	assign i_pin41 = o_pin41;
	gpm_pin_mux i_dut (.*);
	gpm_far_side i_far (.i_mode(md), .i_dma_role(!o_game_port_select), .i_stim(stim), .i_pin39(o_pin39),
		.i_pin39_oe(o_pin39_oe), .i_busy_oe(o_busy_pin_oe), .i_ack_oe(o_ack_pin_oe), .o_pin39(i_pin39),
		.o_busy(i_busy_pin), .o_ack(i_ack_pin));
	// ==========================================
	// helpers
	function automatic logic [7:0] rnd();
		repeat (8) lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic chk(string n, logic x, logic y);
		num_checks++;
		if (x !== y) begin
			failures++;
			$display("mismatch %s expected %b seen %b", n, x, y);
		end
	endtask
	task automatic print_verdict();
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic step();
		gpm_exp_t  x;
		gpm_role_t r;
		logic      pd, fl, ex, pm;
		r = !i_game_select_strap ? GPM_ROLE_DMA : i_game_mode_select ? GPM_ROLE_PORTABLE : GPM_ROLE_ADAPTER;
		{md, i_game_mode_select, i_floppy_ext_polarity, i_ext_mode_polarity, i_powerdown_polarity,
			i_powerdown_input} = rnd();
		{stim, i_game_read_strobe_n, i_game_write_strobe_n, i_dma_ack_chan_a_n, i_motor_enable_b_n,
			i_drive_select_b_n} = rnd();
		i_powerdown_tristate_reg_a = rnd();
		i_powerdown_tristate_reg_b = rnd();
		pd = i_powerdown_input == i_powerdown_polarity;
		fl = md == 3'h1 || md == 3'h3;
		ex = md == 3'h2 || md > 3'h4;
		pm = md == 3'h0 || md > 3'h4;
		x.cs = pd;
		x.gs = i_game_select_strap;
		x.p41e = !(pd && i_powerdown_tristate_reg_a[0]);
		x.p39e = r != GPM_ROLE_DMA && !(pd && i_powerdown_tristate_reg_a[1]);
		x.p41 = r == GPM_ROLE_DMA ? i_dma_ack_chan_a_n : r == GPM_ROLE_PORTABLE ? fl ~^ i_floppy_ext_polarity
			: i_game_read_strobe_n;
		x.p39 = r == GPM_ROLE_PORTABLE ? ex ~^ i_ext_mode_polarity : i_game_write_strobe_n;
		x.boe = fl && !i_motor_enable_b_n && !(pd && i_powerdown_tristate_reg_b[0]);
		x.aoe = fl && !i_drive_select_b_n && !(pd && i_powerdown_tristate_reg_b[1]);
		x.dq = r == GPM_ROLE_DMA && stim[2];
		// pull-down of the previous cycle still on the pin when sampled
		x.pb = pm && stim[0] && !last.boe;
		x.pa = !pm || (stim[1] && !last.aoe);
		x.ir = md == 3'h2 && stim[0] && !last.boe;
		x.ad = md == 3'h2 && stim[1] && !last.aoe;
		q.push_back(x);
		last = x;
	endtask
	// ==========================================
	// clock, monitor, watchdog
	initial begin
		i_ref_clk = 0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	initial forever begin
		@(posedge i_ref_clk);
		avail = q.size();
		#2;
		if (avail > 0) begin
			e = q.pop_front();
			chk("pin41_oe", e.p41e, o_pin41_oe);
			chk("pin39_oe", e.p39e, o_pin39_oe);
			if (e.p41e) chk("pin41", e.p41, o_pin41);
			if (e.p39e) chk("pin39", e.p39, o_pin39);
			chk("busy_oe", e.boe, o_busy_pin_oe);
			chk("ack_oe", e.aoe, o_ack_pin_oe);
			chk("busy_lvl", 1'b0, o_busy_pin);
			chk("ack_lvl", 1'b0, o_ack_pin);
			chk("game_sel", e.gs, o_game_port_select);
			chk("dma_req", e.dq, o_dma_req_chan_a);
			chk("prn_busy", e.pb, o_printer_busy);
			chk("prn_ack", e.pa, o_printer_ack_n);
			chk("irq", e.ir, o_adapter_irq_in);
			chk("dreq", e.ad, o_adapter_dma_req_in);
			chk("clk_stop", e.cs, o_clock_stop);
		end
	end
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
	// ==========================================
	// main sequence: strap high, low, high
	initial begin
		i_arst_n = 0;
		lfsr = 8'h62;
		i_game_select_strap = 1;
		step();
		q.delete();
		for (int k = 0; k < 3; k++) begin
			#1 i_arst_n = 0;
			i_game_select_strap = k != 1;
			repeat (8) @(posedge i_ref_clk);
			#1 chk("game_sel_rst", 1'b1, o_game_port_select);
			i_arst_n = 1;
			repeat (3) @(posedge i_ref_clk);
			repeat (300) begin
				#1 step();
				@(posedge i_ref_clk);
			end
			repeat (2) @(posedge i_ref_clk);
		end
		print_verdict();
	end
endmodule

// ### verilog/gpm_pin_mux.sv
// game port, power-down and parallel status pin multiplexer
`timescale 1ns/10ps
`include "gpm_regs.svh"
module gpm_pin_mux
	import gpm_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_game_select_strap,
	input  wire logic       i_game_mode_select,
	input  wire logic       i_floppy_ext_polarity,
	input  wire logic       i_ext_mode_polarity,
	input  wire logic       i_powerdown_polarity,
	input  wire logic [7:0] i_powerdown_tristate_reg_a,
	input  wire logic [7:0] i_powerdown_tristate_reg_b,
	input  wire logic       i_port_mode_bit0,
	input  wire logic       i_port_mode_bit1,
	input  wire logic       i_port_mode_bit2,
	input  wire logic       i_powerdown_input,
	input  wire logic       i_game_read_strobe_n,
	input  wire logic       i_game_write_strobe_n,
	input  wire logic       i_dma_ack_chan_a_n,
	input  wire logic       i_motor_enable_b_n,
	input  wire logic       i_drive_select_b_n,
	input  wire logic       i_pin41,
	input  wire logic       i_pin39,
	input  wire logic       i_busy_pin,
	input  wire logic       i_ack_pin,
	output logic            o_pin41,
	output logic            o_pin41_oe,
	output logic            o_pin39,
	output logic            o_pin39_oe,
	output logic            o_busy_pin,
	output logic            o_busy_pin_oe,
	output logic            o_ack_pin,
	output logic            o_ack_pin_oe,
	output logic            o_game_port_select,
	output logic            o_dma_req_chan_a,
	output logic            o_printer_busy,
	output logic            o_printer_ack_n,
	output logic            o_adapter_irq_in,
	output logic            o_adapter_dma_req_in,
	output logic            o_clock_stop
);

	// ==========================================
	// declarations
	logic       game_port_select;
	logic       strap_taken;
	gpm_role_t  role;
	gpm_role_t  next_role;
	gpm_pwr_t   pwr;
	gpm_pwr_t   next_pwr;
	logic [2:0] port_mode;
	logic       floppy_ext_active;
	logic       ext_mode_active;
	logic       floppy_ext_indicator;
	logic       ext_mode_indicator;
	logic       pd_request;
	logic       pd_now;
	logic       next_pin41;
	logic       next_pin41_drive;
	logic       next_pin39;
	logic       next_pin39_drive;
	logic       next_busy_drive;
	logic       next_ack_drive;
	logic       busy_is_input;
	logic       ack_is_input;

	// ==========================================
	// mode decode helpers
	function automatic logic is_floppy_mode(input logic [2:0] mode);
		is_floppy_mode = (mode == `GPM_MODE_EXT_FLOPPY) || (mode == `GPM_MODE_DUAL_FLOPPY);
	endfunction

	function automatic logic is_printer_status_mode(input logic [2:0] mode);
		is_printer_status_mode = (mode == `GPM_MODE_PRINTER) || (mode == `GPM_MODE_EPP) ||
			(mode == `GPM_MODE_ECP) || (mode == `GPM_MODE_ECP_EPP);
	endfunction

	assign port_mode = {i_port_mode_bit2, i_port_mode_bit1, i_port_mode_bit0};

	// ==========================================
	// strap capture after reset release
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strap_taken <= `GPM_STRAP_TAKEN_RST;
		end else begin
			strap_taken <= 1'h1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			game_port_select <= `GPM_GAME_SELECT_RST;
		end else if (!strap_taken) begin
			game_port_select <= i_game_select_strap;
		end
	end

	assign o_game_port_select = game_port_select;

	// ==========================================
	// shared pin role
	always_comb begin
		if (!game_port_select) begin
			next_role = GPM_ROLE_DMA;
		end else if (i_game_mode_select) begin
			next_role = GPM_ROLE_PORTABLE;
		end else begin
			next_role = GPM_ROLE_ADAPTER;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			role <= GPM_ROLE_ADAPTER;
		end else begin
			role <= next_role;
		end
	end

	// ==========================================
	// power-down state
	assign pd_request = i_powerdown_polarity ? i_powerdown_input : ~i_powerdown_input;

	always_comb begin
		unique case (pwr)
			GPM_PWR_RUN: begin
				next_pwr = pd_request ? GPM_PWR_DOWN : GPM_PWR_RUN;
			end
			GPM_PWR_DOWN: begin
				next_pwr = pd_request ? GPM_PWR_DOWN : GPM_PWR_RUN;
			end
			default: begin
				next_pwr = GPM_PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pwr <= GPM_PWR_RUN;
		end else begin
			pwr <= next_pwr;
		end
	end

	assign pd_now       = (pwr == GPM_PWR_DOWN);
	assign o_clock_stop = pd_now;

	// ==========================================
	// indicator conditions and levels
	assign floppy_ext_active = is_floppy_mode(port_mode);
	assign ext_mode_active   = (port_mode == `GPM_MODE_EXT_ADAPTER) || (port_mode == `GPM_MODE_EPP) ||
		(port_mode == `GPM_MODE_ECP) || (port_mode == `GPM_MODE_ECP_EPP);

	gpm_polarity u_floppy_pol (
		.i_active      (floppy_ext_active),
		.i_active_high (i_floppy_ext_polarity),
		.o_level       (floppy_ext_indicator)
	);

	gpm_polarity u_ext_pol (
		.i_active      (ext_mode_active),
		.i_active_high (i_ext_mode_polarity),
		.o_level       (ext_mode_indicator)
	);

	// ==========================================
	// shared game port pin selection
	always_comb begin
		unique case (role)
			GPM_ROLE_ADAPTER: begin
				next_pin41       = i_game_read_strobe_n;
				next_pin41_drive = `GPM_DRIVE_ON;
				next_pin39       = i_game_write_strobe_n;
				next_pin39_drive = `GPM_DRIVE_ON;
			end
			GPM_ROLE_PORTABLE: begin
				next_pin41       = floppy_ext_indicator;
				next_pin41_drive = `GPM_DRIVE_ON;
				next_pin39       = ext_mode_indicator;
				next_pin39_drive = `GPM_DRIVE_ON;
			end
			GPM_ROLE_DMA: begin
				next_pin41       = i_dma_ack_chan_a_n;
				next_pin41_drive = `GPM_DRIVE_ON;
				next_pin39       = `GPM_PIN_LEVEL_RST;
				next_pin39_drive = `GPM_DRIVE_OFF;
			end
			default: begin
				next_pin41       = `GPM_PIN_LEVEL_RST;
				next_pin41_drive = `GPM_DRIVE_OFF;
				next_pin39       = `GPM_PIN_LEVEL_RST;
				next_pin39_drive = `GPM_DRIVE_OFF;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pin41    <= `GPM_PIN_LEVEL_RST;
			o_pin41_oe <= `GPM_DRIVE_OFF;
		end else begin
			o_pin41    <= next_pin41;
			o_pin41_oe <= next_pin41_drive && !(pd_request && i_powerdown_tristate_reg_a[`GPM_PD_A_GAME_RD_BIT]);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pin39    <= `GPM_PIN_LEVEL_RST;
			o_pin39_oe <= `GPM_DRIVE_OFF;
		end else begin
			o_pin39    <= next_pin39;
			o_pin39_oe <= next_pin39_drive && !(pd_request && i_powerdown_tristate_reg_a[`GPM_PD_A_GAME_WR_BIT]);
		end
	end

	// ==========================================
	// dma request taken from pin39
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_dma_req_chan_a <= `GPM_STATUS_RST;
		end else begin
			o_dma_req_chan_a <= (role == GPM_ROLE_DMA) ? i_pin39 : `GPM_STATUS_RST;
		end
	end

	// ==========================================
	// parallel BUSY and ACK pins, open drain in floppy modes
	always_comb begin
		next_busy_drive = `GPM_DRIVE_OFF;
		next_ack_drive  = `GPM_DRIVE_OFF;
		busy_is_input   = 1'h0;
		ack_is_input    = 1'h0;
		if (is_floppy_mode(port_mode)) begin
			next_busy_drive = ~i_motor_enable_b_n;
			next_ack_drive  = ~i_drive_select_b_n;
		end else if (port_mode == `GPM_MODE_EXT_ADAPTER) begin
			busy_is_input = 1'h1;
			ack_is_input  = 1'h1;
		end else if (port_mode == `GPM_MODE_JOYSTICK) begin
			busy_is_input = 1'h0;
			ack_is_input  = 1'h0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_busy_pin    <= `GPM_OD_LEVEL;
			o_busy_pin_oe <= `GPM_DRIVE_OFF;
		end else begin
			o_busy_pin    <= `GPM_OD_LEVEL;
			o_busy_pin_oe <= next_busy_drive && !(pd_request && i_powerdown_tristate_reg_b[`GPM_PD_B_BUSY_BIT]);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ack_pin    <= `GPM_OD_LEVEL;
			o_ack_pin_oe <= `GPM_DRIVE_OFF;
		end else begin
			o_ack_pin    <= `GPM_OD_LEVEL;
			o_ack_pin_oe <= next_ack_drive && !(pd_request && i_powerdown_tristate_reg_b[`GPM_PD_B_ACK_BIT]);
		end
	end

	// ==========================================
	// printer status toward the core
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_printer_busy <= `GPM_STATUS_RST;
		end else begin
			o_printer_busy <= is_printer_status_mode(port_mode) ? i_busy_pin : `GPM_STATUS_RST;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_printer_ack_n <= `GPM_PIN_LEVEL_RST;
		end else begin
			o_printer_ack_n <= is_printer_status_mode(port_mode) ? i_ack_pin : `GPM_PIN_LEVEL_RST;
		end
	end

	// ==========================================
	// adapter requests toward the core
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_adapter_irq_in <= `GPM_STATUS_RST;
		end else begin
			o_adapter_irq_in <= busy_is_input ? i_busy_pin : `GPM_STATUS_RST;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_adapter_dma_req_in <= `GPM_STATUS_RST;
		end else begin
			o_adapter_dma_req_in <= ack_is_input ? i_ack_pin : `GPM_STATUS_RST;
		end
	end

endmodule

// ### verilog/gpm_pkg.sv
// types for the game port, power-down and parallel status pin multiplexer
package gpm_pkg;

	// ==========================================
	// role of the two shared game port pins
	typedef enum logic [2:0] {
		GPM_ROLE_ADAPTER  = 3'h1,
		GPM_ROLE_PORTABLE = 3'h2,
		GPM_ROLE_DMA      = 3'h4
	} gpm_role_t;

	// ==========================================
	// power state
	typedef enum logic [1:0] {
		GPM_PWR_RUN  = 2'h1,
		GPM_PWR_DOWN = 2'h2
	} gpm_pwr_t;

endpackage

// ### verilog/gpm_polarity.sv
// polarity-programmable indicator level
`timescale 1ns/10ps
module gpm_polarity (
	input  wire logic i_active,
	input  wire logic i_active_high,
	output logic      o_level
);

	// ==========================================
	// level from condition and polarity
	assign o_level = i_active_high ? i_active : ~i_active;

endmodule

// ### verilog/gpm_regs.svh
// constants for the game port, power-down and parallel status pin multiplexer
// What this block does
// - game select 1: mode bit picks adapter/portable
// - game select 0: shared pins carry DMA A
// - adapter mode: first pin is read strobe
// - adapter mode: second pin is write strobe
// - DMA: first pin ack out, second request in
// - portable: floppy indicator, polarity bit, default low
// - portable: extended indicator for adapter/EPP/ECP modes
// - extended indicator polarity from bit, default low
// - power-down stops clock, tristates selected pins
// - power-down input polarity bit, default high
// - three-bit mode field selects eight functions
// - single floppy: BUSY is drive B motor
// - dual floppy: BUSY is shared motor enable
// - adapter mode: BUSY is adapter interrupt input
// - single floppy: ACK is drive B select
// - dual floppy: ACK is shared drive select
// - adapter mode: ACK is adapter DMA request input
// - joystick mode: BUSY and ACK unused
// - strap latches game select after reset release, default 1
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH

// ==========================================
// parallel port mode field codes
`define GPM_MODE_PRINTER     3'h0
`define GPM_MODE_EXT_FLOPPY  3'h1
`define GPM_MODE_EXT_ADAPTER 3'h2
`define GPM_MODE_DUAL_FLOPPY 3'h3
`define GPM_MODE_JOYSTICK    3'h4
`define GPM_MODE_EPP         3'h5
`define GPM_MODE_ECP         3'h6
`define GPM_MODE_ECP_EPP     3'h7

// ==========================================
// power-down tristate select bit positions
`define GPM_PD_A_GAME_RD_BIT 0
`define GPM_PD_A_GAME_WR_BIT 1
`define GPM_PD_B_BUSY_BIT    0
`define GPM_PD_B_ACK_BIT     1

// ==========================================
// reset values
`define GPM_GAME_SELECT_RST  1'h1
`define GPM_PIN_LEVEL_RST    1'h1
`define GPM_STATUS_RST       1'h0
`define GPM_STRAP_TAKEN_RST  1'h0
`define GPM_DRIVE_OFF        1'h0
`define GPM_DRIVE_ON         1'h1
`define GPM_OD_LEVEL         1'h0

`endif
